//--- design/wpd_pkg.sv
/*
  Constants shared by the wakeup-pin debouncer: register offsets, field
  positions, reset values, debounce counts and the debouncer state type.
  Assumes a byte-addressed register port with 32-bit aligned words.
*/
package wpd_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] WPD_OFF_MODE = 8'h00;
  localparam logic [7:0] WPD_OFF_INPUTS = 8'h04;
  localparam logic [7:0] WPD_OFF_STATUS = 8'h08;
  localparam logic [7:0] WPD_OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] WPD_OFF_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] WPD_OFF_IRQ_ENABLE = 8'h14;

  // ==========================================================
  // Field positions
  localparam int unsigned WPD_MODE_DBC_LSB = 0;
  localparam int unsigned WPD_MODE_DBC_W = 3;
  localparam int unsigned WPD_MODE_TAMPER_LSB = 4;
  localparam int unsigned WPD_INPUTS_EN_LSB = 0;
  localparam int unsigned WPD_INPUTS_POL_LSB = 16;
  localparam int unsigned WPD_STATUS_SRC_LSB = 0;
  localparam int unsigned WPD_STATUS_WAKE_BIT = 16;
  localparam int unsigned WPD_STATUS_TAMPER_LSB = 17;
  localparam int unsigned WPD_IRQ_WAKE_BIT = 0;
  localparam int unsigned WPD_IRQ_TAMPER_LSB = 1;
  localparam int unsigned WPD_IRQ_W = 3;
  localparam int unsigned WPD_TAMPER_N = 2;

  // ==========================================================
  // Reset values
  localparam logic [31:0] WPD_MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] WPD_INPUTS_RESET = 32'h0000_0000;
  localparam logic [2:0] WPD_IRQ_RESET = 3'h0;

  // ==========================================================
  // Debounce counts in slow clock cycles
  localparam int unsigned WPD_CNT_W = 16;
  localparam logic [15:0] WPD_DBC_CYC_IMM = 16'h0001;
  localparam logic [15:0] WPD_DBC_CYC_3 = 16'h0003;
  localparam logic [15:0] WPD_DBC_CYC_32 = 16'h0020;
  localparam logic [15:0] WPD_DBC_CYC_512 = 16'h0200;
  localparam logic [15:0] WPD_DBC_CYC_4096 = 16'h1000;
  localparam int unsigned WPD_DBC_CYC_LONG_DEFAULT = 32768;
  localparam int unsigned WPD_TAMPER_CYC_DEFAULT = 16;
  localparam int unsigned WPD_PINS_DEFAULT = 14;

  // ==========================================================
  // Shared debouncer states
  typedef enum logic [2:0] {
    WPD_ST_IDLE = 3'b001,
    WPD_ST_COUNT = 3'b010,
    WPD_ST_HELD = 3'b100
  } wpd_dbc_state_t;

endpackage : wpd_pkg

//--- design/wpd_tamper_filter.sv
/*
  Low-power tamper debouncer for one wakeup input.
  Assumes pin_active is already synchronised to clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none

module wpd_tamper_filter
  import wpd_pkg::*;
#(
  parameter int unsigned CYCLES = WPD_TAMPER_CYC_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic pin_active,
  output logic tamper_hit
);

  localparam logic [15:0] CYC = 16'(CYCLES);

  if (CYCLES < 1 || CYCLES > 65535) begin : g_chk
    $error("wpd_tamper_filter: CYCLES out of range");
  end

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic hit_reg;
  logic hit_next;

  // ==========================================================
  // Consecutive-active counter, one hit per active period
  always_comb begin
    cnt_next = cnt_reg;
    hit_next = 1'b0;
    if (!enable || !pin_active) begin
      cnt_next = 16'h0000;
    end else if (cnt_reg != CYC) begin
      cnt_next = cnt_reg + 16'h0001;
      hit_next = (cnt_next == CYC);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt_reg <= 16'h0000;
      hit_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      hit_reg <= hit_next;
    end
  end

  assign tamper_hit = hit_reg;

  // ==========================================================
  // Checks
  hit_cause_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    tamper_hit |-> $past(enable) && $past(pin_active))
    else $error("tamper hit without enabled active input");
  hit_single_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    tamper_hit |=> !tamper_hit)
    else $error("tamper hit longer than one cycle");

endmodule : wpd_tamper_filter

`default_nettype wire

//--- design/wpd_wakeup_debouncer.sv
/*
  Wakeup-pin debouncer with two low-power tamper debouncers and a small
  register port. Runs on the slow clock; wakeup pins are asynchronous.
  Registers are reset only by reset_n, the backup-domain reset.
*/
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Enabled wakeup pins are ORed into one shared debounce counter.
// - Select field picks 3, 32, 512, 4096 or 32768 cycle periods.
// - Select zero wakes after one cycle of an active enabled pin.
// - Active for the full period starts core wakeup and captures all pins.
// - A later wakeup overwrites the captured source record.
// - Two separate low-power debouncers serve wakeup inputs zero and one.
// - Tamper enable bit makes its debouncer raise a system wakeup.
// - Tamper detection also works while the core supply is powered.
// - RTC waveform outputs keep running in backup and low-power modes.
// - Mode, input and status registers live in the backup domain.
module wpd_wakeup_debouncer
  import wpd_pkg::*;
#(
  parameter int unsigned PINS = WPD_PINS_DEFAULT,
  parameter int unsigned DBC_LONG_CYCLES = WPD_DBC_CYC_LONG_DEFAULT,
  parameter int unsigned TAMPER_CYCLES = WPD_TAMPER_CYC_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [PINS-1:0] wakeup_pin,
  input wire logic core_powered,
  input wire logic [1:0] rtc_wave_src,
  output logic [1:0] rtc_waveform_output,
  output logic core_wakeup_start,
  output logic irq
);

  localparam logic [15:0] DBC_LONG = 16'(DBC_LONG_CYCLES);

  if (PINS < WPD_TAMPER_N || PINS > 16) begin : g_chk_pins
    $error("wpd_wakeup_debouncer: PINS must be 2 to 16");
  end
  if (DBC_LONG_CYCLES <= 4096 || DBC_LONG_CYCLES > 65535) begin : g_chk_long
    $error("wpd_wakeup_debouncer: DBC_LONG_CYCLES out of range");
  end

  // ==========================================================
  // Pin synchronisers
  logic [PINS-1:0] pin_meta_reg;
  logic [PINS-1:0] pin_sync_reg;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= wakeup_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ==========================================================
  // Registers
  logic [31:0] mode_reg;
  logic [31:0] mode_next;
  logic [31:0] inputs_reg;
  logic [31:0] inputs_next;
  logic [2:0] irq_en_reg;
  logic [2:0] irq_en_next;
  logic [2:0] irq_st_reg;
  logic [2:0] irq_st_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [PINS-1:0] src_reg;
  logic [PINS-1:0] src_next;
  logic wake_seen_reg;
  logic wake_seen_next;
  logic [1:0] tamper_seen_reg;
  logic [1:0] tamper_seen_next;

  logic [2:0] dbc_sel;
  logic [1:0] tamper_en;
  logic [PINS-1:0] pin_en;
  logic [PINS-1:0] pin_pol;
  logic [PINS-1:0] pin_active;
  logic combined;
  logic [15:0] period;
  logic [1:0] tamper_hit;
  logic [2:0] irq_events;
  logic [31:0] status_word;

  assign dbc_sel = mode_reg[WPD_MODE_DBC_LSB +: WPD_MODE_DBC_W];
  assign tamper_en = mode_reg[WPD_MODE_TAMPER_LSB +: WPD_TAMPER_N];
  assign pin_en = inputs_reg[WPD_INPUTS_EN_LSB +: PINS];
  assign pin_pol = inputs_reg[WPD_INPUTS_POL_LSB +: PINS];
  assign pin_active = ~(pin_sync_reg ^ pin_pol);
  assign combined = |(pin_active & pin_en);

  // Period lookup
  always_comb begin
    case (dbc_sel)
      3'h0: period = WPD_DBC_CYC_IMM;
      3'h1: period = WPD_DBC_CYC_3;
      3'h2: period = WPD_DBC_CYC_32;
      3'h3: period = WPD_DBC_CYC_512;
      3'h4: period = WPD_DBC_CYC_4096;
      default: period = DBC_LONG;
    endcase
  end

  // ==========================================================
  // Shared debounce counter
  wpd_dbc_state_t state_reg;
  wpd_dbc_state_t state_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic fire_reg;
  logic fire_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    fire_next = 1'b0;
    case (state_reg)
      WPD_ST_IDLE: begin
        cnt_next = 16'h0000;
        if (combined) begin
          cnt_next = 16'h0001;
          if (16'h0001 >= period) begin
            fire_next = 1'b1;
            state_next = WPD_ST_HELD;
          end else begin
            state_next = WPD_ST_COUNT;
          end
        end
      end
      WPD_ST_COUNT: begin
        if (!combined) begin
          cnt_next = 16'h0000;
          state_next = WPD_ST_IDLE;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
          if (cnt_next >= period) begin
            fire_next = 1'b1;
            state_next = WPD_ST_HELD;
          end
        end
      end
      WPD_ST_HELD: begin
        // No new wakeup until the condition has gone away
        if (!combined) begin
          cnt_next = 16'h0000;
          state_next = WPD_ST_IDLE;
        end
      end
      default: begin
        cnt_next = 16'h0000;
        state_next = WPD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= WPD_ST_IDLE;
      cnt_reg <= 16'h0000;
      fire_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      fire_reg <= fire_next;
    end
  end

  // ==========================================================
  // Tamper debouncers on inputs zero and one
  for (genvar i = 0; i < WPD_TAMPER_N; i++) begin : g_tamper
    wpd_tamper_filter #(
      .CYCLES(TAMPER_CYCLES)
    ) u_filter (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .enable(tamper_en[i]),
      .pin_active(pin_active[i]),
      .tamper_hit(tamper_hit[i])
    );
  end

  // ==========================================================
  // Register writes, captures and interrupts
  assign irq_events = {tamper_hit, fire_reg};

  always_comb begin
    mode_next = mode_reg;
    inputs_next = inputs_reg;
    irq_en_next = irq_en_reg;
    irq_st_next = irq_st_reg;
    src_next = src_reg;
    wake_seen_next = wake_seen_reg;
    tamper_seen_next = tamper_seen_reg | tamper_hit;
    if (reg_wr) begin
      case (reg_addr)
        WPD_OFF_MODE: mode_next = reg_wdata;
        WPD_OFF_INPUTS: inputs_next = reg_wdata;
        WPD_OFF_IRQ_ENABLE: irq_en_next = reg_wdata[WPD_IRQ_W-1:0];
        WPD_OFF_IRQ_CLEAR: irq_st_next = irq_st_reg & ~reg_wdata[2:0];
        default: ;
      endcase
    end
    irq_st_next = irq_st_next | irq_events;
    if (fire_next) begin
      src_next = pin_active;
      wake_seen_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    // Only the backup-domain reset clears these; core power is ignored
    if (!reset_n) begin
      mode_reg <= WPD_MODE_RESET;
      inputs_reg <= WPD_INPUTS_RESET;
      irq_en_reg <= WPD_IRQ_RESET;
      irq_st_reg <= WPD_IRQ_RESET;
      src_reg <= '0;
      wake_seen_reg <= 1'b0;
      tamper_seen_reg <= 2'h0;
    end else begin
      mode_reg <= mode_next;
      inputs_reg <= inputs_next;
      irq_en_reg <= irq_en_next;
      irq_st_reg <= irq_st_next;
      src_reg <= src_next;
      wake_seen_reg <= wake_seen_next;
      tamper_seen_reg <= tamper_seen_next;
    end
  end

  // ==========================================================
  // Read port
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[WPD_STATUS_SRC_LSB +: PINS] = src_reg;
    status_word[WPD_STATUS_WAKE_BIT] = wake_seen_reg;
    status_word[WPD_STATUS_TAMPER_LSB +: WPD_TAMPER_N] = tamper_seen_reg;
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        WPD_OFF_MODE: rdata_next = mode_reg;
        WPD_OFF_INPUTS: rdata_next = inputs_reg;
        WPD_OFF_STATUS: rdata_next = status_word;
        WPD_OFF_IRQ_STATUS: rdata_next = {29'h0, irq_st_reg};
        WPD_OFF_IRQ_ENABLE: rdata_next = {29'h0, irq_en_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Outputs
  logic wake_out_reg;
  logic [1:0] rtc_reg;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdata_reg <= 32'h0000_0000;
      wake_out_reg <= 1'b0;
      rtc_reg <= 2'h0;
    end else begin
      rdata_reg <= rdata_next;
      wake_out_reg <= fire_next | (|tamper_hit);
      rtc_reg <= rtc_wave_src;
    end
  end

  assign reg_rdata = rdata_reg;
  assign core_wakeup_start = wake_out_reg;
  assign rtc_waveform_output = rtc_reg;
  assign irq = |(irq_st_reg & irq_en_reg);

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  no_pin_a: assert property (state_reg == WPD_ST_IDLE &&
    (pin_active & pin_en) == '0 |=> !fire_reg)
    else $error("wakeup fired with no enabled active pin");
  period_a: assert property (fire_reg |-> cnt_reg == $past(period))
    else $error("wakeup fired at wrong count");
  immediate_a: assert property (state_reg == WPD_ST_IDLE && combined &&
    dbc_sel == 3'h0 |=> fire_reg && core_wakeup_start)
    else $error("immediate wakeup not raised");
  capture_a: assert property (fire_reg |-> src_reg == $past(pin_active)
    && wake_seen_reg)
    else $error("wakeup sources not captured");
  overwrite_a: assert property (fire_reg && $past(wake_seen_reg) |->
    src_reg == $past(pin_active))
    else $error("later wakeup did not overwrite sources");
  tamper_wake_a: assert property (tamper_hit[0] || tamper_hit[1] |=>
    core_wakeup_start && irq_st_reg[2:1] != 2'h0)
    else $error("tamper hit raised no wakeup");
  tamper_core_a: assert property (core_powered && tamper_en[0] &&
    pin_active[0] && !reg_wr [*8] |-> tamper_hit[0] || $past(tamper_hit[0])
    || g_tamper[0].u_filter.cnt_reg != 16'h0000)
    else $error("tamper input idle while core powered");
  rtc_pass_a: assert property ($past(reset_n) |->
    rtc_waveform_output == $past(rtc_wave_src))
    else $error("rtc waveform output altered");
  backup_hold_a: assert property ($fell(core_powered) && !$past(reg_wr) |->
    $stable(mode_reg) && $stable(inputs_reg) && $stable(src_reg))
    else $error("backup registers lost on core power change");
  restart_a: assert property (state_reg == WPD_ST_COUNT && !combined |=>
    cnt_reg == 16'h0000 && state_reg == WPD_ST_IDLE ##1
    cnt_reg <= 16'h0001)
    else $error("counter did not restart");
  irq_set_a: assert property (irq_events[0] |=> irq_st_reg[0])
    else $error("wakeup event lost against clear");

  cov_immediate_c: cover property (dbc_sel == 3'h0 && fire_reg);
  cov_counted_c: cover property (dbc_sel == 3'h1 && fire_reg);
  cov_restart_c: cover property (state_reg == WPD_ST_COUNT && !combined);
  cov_tamper_c: cover property (tamper_hit[1] && core_powered);

endmodule : wpd_wakeup_debouncer

`default_nettype wire

//--- dv/wpd_pin_model.sv
/*
  Far-side model: wakeup pins held by pull-ups and two tamper switches.
  Assumes the bench commands pin levels and switch states, and that the
  tamper switches are powered from the block's waveform outputs.
*/
`timescale 1ns/100ps
`default_nettype none

module wpd_pin_model
  import wpd_pkg::*;
#(
  parameter int unsigned PINS = WPD_PINS_DEFAULT
) (
  input wire logic [PINS-1:0] pin_cmd,
  input wire logic [1:0] tamper_closed,
  input wire logic [1:0] rtc_waveform_output,
  output logic [PINS-1:0] wakeup_pin
);
  // ==========================================================
  // Pin levels
  always_comb begin
    wakeup_pin = pin_cmd;
    for (int i = 0; i < 2; i++) begin
      // Closed switch pulls low only while its waveform powers it
      if (tamper_closed[i] && rtc_waveform_output[i]) begin
        wakeup_pin[i] = 1'b0;
      end
    end
  end
endmodule : wpd_pin_model

`default_nettype wire

//--- dv/wpd_wakeup_debouncer_tb.sv
/*
  Self-checking bench for the wakeup-pin debouncer.
  Assumes the register map and latencies of the design package.
*/
`timescale 1ns/100ps
`default_nettype none

module wpd_wakeup_debouncer_tb;
  import wpd_pkg::*;
  localparam int unsigned LONG = 5000;
  logic clk_sys, reset_n, reg_wr, reg_rd, core_powered, core_wakeup_start;
  logic irq;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] pin_cmd, wakeup_pin;
  logic [1:0] tamper_closed, rtc_wave_src, rtc_waveform_output;
  int failures, n_compared, n;
  int exp_lat[6] = '{3, 5, 34, 514, 4098, LONG + 2};

  wpd_wakeup_debouncer #(.PINS(4), .DBC_LONG_CYCLES(LONG),
    .TAMPER_CYCLES(2)) DUT (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wakeup_pin(wakeup_pin),
    .core_powered(core_powered), .rtc_wave_src(rtc_wave_src),
    .rtc_waveform_output(rtc_waveform_output),
    .core_wakeup_start(core_wakeup_start), .irq(irq));

  wpd_pin_model #(.PINS(4)) partner (.pin_cmd(pin_cmd),
    .tamper_closed(tamper_closed),
    .rtc_waveform_output(rtc_waveform_output), .wakeup_pin(wakeup_pin));

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
    @(posedge clk_sys);
  endtask : rdc

  // Edges until the wakeup pulse, or limit if none
  task automatic wait_wake(input int limit);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (core_wakeup_start !== 1'b1 && n < limit);
    // Back onto a rising edge so later drives stay edge-aligned
    @(posedge clk_sys);
  endtask : wait_wake

  task automatic conclude();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  // ==========================================================
  // Clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    failures++;
    conclude();
  end

  // ==========================================================
  // Tests
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    core_powered = 1'b1;
    rtc_wave_src = 2'h3;
    pin_cmd = 4'hF;
    tamper_closed = 2'h0;
    failures = 0;
    n_compared = 0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rdc(WPD_OFF_MODE, WPD_MODE_RESET);
    rdc(WPD_OFF_INPUTS, WPD_INPUTS_RESET);
    rdc(WPD_OFF_STATUS, 32'h0);
    rdc(WPD_OFF_IRQ_STATUS, 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    rdc(8'h20, 32'h0);
    wr(WPD_OFF_STATUS, 32'hFFFF_FFFF);
    rdc(WPD_OFF_STATUS, 32'h0);
    wr(WPD_OFF_IRQ_ENABLE, 32'hFFFF_FFFF);
    rdc(WPD_OFF_IRQ_ENABLE, 32'h7);
    rdc(WPD_OFF_IRQ_CLEAR, 32'h0);
    $display("test registers done");

    wr(WPD_OFF_INPUTS, 32'h0000_0004);
    wr(WPD_OFF_IRQ_ENABLE, 32'h1);
    for (int s = 0; s < 6; s++) begin
      wr(WPD_OFF_MODE, s);
      pin_cmd[2] <= 1'b0;
      wait_wake(6000);
      check(n, exp_lat[s]);
      rdc(WPD_OFF_STATUS, 32'h0001_0004);
      rdc(WPD_OFF_IRQ_STATUS, 32'h1);
      check(irq, 1'b1);
      if (s == 0) begin
        wr(WPD_OFF_IRQ_ENABLE, 32'h0);
        check(irq, 1'b0);
        wr(WPD_OFF_IRQ_ENABLE, 32'h1);
      end
      pin_cmd[2] <= 1'b1;
      wr(WPD_OFF_IRQ_CLEAR, 32'h1);
      rdc(WPD_OFF_IRQ_STATUS, 32'h0);
      check(irq, 1'b0);
    end
    $display("test debounce periods done");

    wr(WPD_OFF_MODE, 32'h1);
    pin_cmd[2] <= 1'b0;
    @(posedge clk_sys);
    pin_cmd[2] <= 1'b1;
    wait_wake(20);
    check(n, 20);
    pin_cmd[2] <= 1'b0;
    wait_wake(50);
    check(n, 5);
    pin_cmd[2] <= 1'b1;
    $display("test short pulse done");

    wr(WPD_OFF_MODE, 32'h0);
    wr(WPD_OFF_INPUTS, 32'h0000_0002);
    pin_cmd <= 4'b0111;
    wait_wake(20);
    check(n, 20);
    pin_cmd <= 4'b0101;
    wait_wake(20);
    check(n, 3);
    rdc(WPD_OFF_STATUS, 32'h0001_000A);
    pin_cmd <= 4'hF;
    $display("test overwrite done");

    core_powered <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rtc_wave_src <= 2'(i);
      @(posedge clk_sys);
      #1;
      check(rtc_waveform_output, i);
      @(posedge clk_sys);
    end
    rtc_wave_src <= 2'h3;
    core_powered <= 1'b1;
    $display("test waveform done");

    wr(WPD_OFF_INPUTS, 32'h0);
    wr(WPD_OFF_IRQ_CLEAR, 32'h7);
    wr(WPD_OFF_IRQ_ENABLE, 32'h6);
    wr(WPD_OFF_MODE, 32'h10);
    tamper_closed <= 2'h3;
    wait_wake(20);
    check(n < 20, 1'b1);
    rdc(WPD_OFF_STATUS, 32'h0003_000A);
    rdc(WPD_OFF_IRQ_STATUS, 32'h2);
    check(irq, 1'b1);
    tamper_closed <= 2'h0;
    wr(WPD_OFF_MODE, 32'h20);
    // No enabled wakeup pin is active before backup
    core_powered <= 1'b0;
    tamper_closed <= 2'h2;
    wait_wake(20);
    check(n < 20, 1'b1);
    rdc(WPD_OFF_STATUS, 32'h0007_000A);
    rdc(WPD_OFF_IRQ_STATUS, 32'h6);
    rdc(WPD_OFF_MODE, 32'h20);
    rdc(WPD_OFF_INPUTS, 32'h0);
    $display("test tamper done");
    conclude();
  end
endmodule : wpd_wakeup_debouncer_tb

`default_nettype wire
